// >>> design/dcdc_mode_and_ask_control.sv
// Step-down converter mode sequencer and ASK modulation switch control
// Operation
// - Converter switches at nominal 3 MHz when on
// - Mode bit zero selects direct charge mode
// - Enable one starts converter in selected mode
// - Enable zero stops converter, enters waiting
// - Status pin low running, high off
// - Protection stop or completion clears enable bit
// - Capacitor switches follow capacitive modulation input
// - Resistor switch follows resistive modulation input
// - Register bits can drive modulation switches instead
// - Charge runs trickle, pre, fast, then taper
// - Phases decided from feedback and sense inputs
// - Trickle when enabled and battery low
// - Taper ends at termination current if enabled
// - Mode bit one selects constant voltage feed
// - Feed soft start steps current limit upward
`timescale 1ns/10ps
module dcdc_mode_and_ask_control
  import dcdc_ctrl_pkg::*;
#(
  parameter int SS_CYCLES = SS_STEP_CYC
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_set_in,
  input wire logic enable_clear_in,
  input config_s cfg_in,
  input wire logic protection_stop_in,
  input sense_s sense_in,
  input wire logic cap_modulation_input_in,
  input wire logic res_modulation_input_in,
  output logic converter_enable_bit_out,
  output conv_state_e state_out,
  output logic converter_status_out,
  output logic switch_pulse_out,
  output logic [11:0] current_limit_out,
  output logic cap_switch_out_a_out,
  output logic cap_switch_out_a_oe_out,
  output logic cap_switch_out_b_out,
  output logic cap_switch_out_b_oe_out,
  output logic resistor_switch_out_out,
  output logic resistor_switch_out_oe_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers (three stages, change once stages 2 and 3 agree)
  // ----------------------------------------------------------------
  logic [2:0] cap_sync;
  logic [2:0] res_sync;
  logic [4:0] sens_sync1;
  logic [4:0] sens_sync2;
  logic [4:0] sens_sync3;
  logic cap_level;
  logic res_level;
  sense_s sense_level;
  logic prot_level;
  logic [4:0] next_sens;
  logic next_cap;
  logic next_res;

  always_comb
  begin
    next_cap = cap_level;
    next_res = res_level;
    next_sens = {prot_level, sense_level};
    if (cap_sync[1] == cap_sync[2])
    begin
      next_cap = cap_sync[2];
    end
    if (res_sync[1] == res_sync[2])
    begin
      next_res = res_sync[2];
    end
    for (int i = 0; i < 5; i++)
    begin
      if (sens_sync2[i] == sens_sync3[i])
      begin
        next_sens[i] = sens_sync3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cap_sync <= 3'h0;
      res_sync <= 3'h0;
      sens_sync1 <= 5'h00;
      sens_sync2 <= 5'h00;
      sens_sync3 <= 5'h00;
      cap_level <= 1'h0;
      res_level <= 1'h0;
      sense_level <= '0;
      prot_level <= 1'h0;
    end
    else
    begin
      cap_sync <= {cap_sync[1:0], cap_modulation_input_in};
      res_sync <= {res_sync[1:0], res_modulation_input_in};
      sens_sync1 <= {protection_stop_in, sense_in};
      sens_sync2 <= sens_sync1;
      sens_sync3 <= sens_sync2;
      cap_level <= next_cap;
      res_level <= next_res;
      {prot_level, sense_level} <= next_sens;
    end
  end

  // ----------------------------------------------------------------
  // Enable bit and mode sequencer
  // ----------------------------------------------------------------
  conv_state_e state;
  conv_state_e next_state;
  logic enable;
  logic next_enable;
  logic [$clog2(SS_CYCLES + 1)-1:0] ss_count;
  logic [$clog2(SS_CYCLES + 1)-1:0] next_ss_count;
  logic [1:0] ss_step;
  logic [1:0] next_ss_step;
  logic auto_stop;

  always_comb
  begin
    next_state = state;
    next_ss_count = ss_count;
    next_ss_step = ss_step;
    auto_stop = 1'b0;
    case (state)
      ST_WAIT:
      begin
        if (enable)
        begin
          next_ss_count = '0;
          next_ss_step = 2'h0;
          if (cfg_in.mode_select_bit)
          begin
            next_state = ST_SOFT;
          end
          else if (cfg_in.trickle_enable_bit && sense_level.batt_low)
          begin
            next_state = ST_TRICKLE;
          end
          else
          begin
            next_state = ST_PRE;
          end
        end
      end
      ST_TRICKLE:
      begin
        if (!sense_level.batt_low)
        begin
          next_state = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (sense_level.batt_fast)
        begin
          next_state = ST_FAST;
        end
      end
      ST_FAST:
      begin
        if (sense_level.batt_cv)
        begin
          next_state = ST_TAPER;
        end
      end
      ST_TAPER:
      begin
        if (cfg_in.termination_enable_bit && sense_level.current_term)
        begin
          auto_stop = 1'b1;
        end
      end
      ST_SOFT:
      begin
        if (ss_count == SS_CYCLES[$bits(ss_count)-1:0] - 1'b1)
        begin
          next_ss_count = '0;
          if (ss_step == 2'(SS_STEPS - 1))
          begin
            next_state = ST_FEED;
          end
          else
          begin
            next_ss_step = ss_step + 2'h1;
          end
        end
        else
        begin
          next_ss_count = ss_count + 1'b1;
        end
      end
      ST_FEED: next_state = ST_FEED;
      default: next_state = ST_WAIT;
    endcase
    if (state != ST_WAIT && prot_level)
    begin
      auto_stop = 1'b1;
    end
    // Host clear and automatic stop outrank a same-cycle set
    next_enable = enable;
    if (enable_set_in)
    begin
      next_enable = 1'b1;
    end
    if (enable_clear_in || auto_stop)
    begin
      next_enable = 1'b0;
    end
    if (!enable || auto_stop)
    begin
      next_state = ST_WAIT;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= ST_WAIT;
      enable <= 1'b0;
      ss_count <= '0;
      ss_step <= 2'h0;
    end
    else
    begin
      state <= next_state;
      enable <= next_enable;
      ss_count <= next_ss_count;
      ss_step <= next_ss_step;
    end
  end

  // ----------------------------------------------------------------
  // Switching enable pulse and status outputs
  // ----------------------------------------------------------------
  logic [$clog2(SW_DIV + 1)-1:0] sw_count;
  logic [$clog2(SW_DIV + 1)-1:0] next_sw_count;
  logic next_pulse;
  logic next_status;
  logic [11:0] next_limit;

  always_comb
  begin
    next_sw_count = '0;
    next_pulse = 1'b0;
    if (state != ST_WAIT)
    begin
      if (sw_count == SW_DIV[$bits(sw_count)-1:0] - 1'b1)
      begin
        next_pulse = 1'b1;
      end
      else
      begin
        next_sw_count = sw_count + 1'b1;
      end
    end
    next_status = (state == ST_WAIT);
    case (state)
      ST_SOFT: next_limit = 12'(OCL_STEP_MA * (ss_step + 2'h1));
      ST_FEED: next_limit = OCL_CV_MA;
      ST_WAIT: next_limit = OCL_OFF_MA;
      default: next_limit = OCL_CV_MA;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sw_count <= '0;
      switch_pulse_out <= 1'b0;
      converter_status_out <= 1'b1;
      current_limit_out <= OCL_OFF_MA;
    end
    else
    begin
      sw_count <= next_sw_count;
      switch_pulse_out <= next_pulse;
      converter_status_out <= next_status;
      current_limit_out <= next_limit;
    end
  end

  // ----------------------------------------------------------------
  // ASK modulation switches (open drain: oe high pulls low)
  // ----------------------------------------------------------------
  logic cap_on;
  logic res_on;
  logic next_cap_on;
  logic next_res_on;

  always_comb
  begin
    if (cfg_in.mod_use_bits)
    begin
      next_cap_on = cfg_in.cap_modulation_bit;
      next_res_on = cfg_in.res_modulation_bit;
    end
    else
    begin
      next_cap_on = cap_level;
      next_res_on = res_level;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cap_on <= 1'b0;
      res_on <= 1'b0;
    end
    else
    begin
      cap_on <= next_cap_on;
      res_on <= next_res_on;
    end
  end

  assign converter_enable_bit_out = enable;
  assign state_out = state;
  assign cap_switch_out_a_out = 1'b0;
  assign cap_switch_out_b_out = 1'b0;
  assign resistor_switch_out_out = 1'b0;
  assign cap_switch_out_a_oe_out = cap_on;
  assign cap_switch_out_b_oe_out = cap_on;
  assign resistor_switch_out_oe_out = res_on;

endmodule // dcdc_mode_and_ask_control

// >>> design/dcdc_ctrl_pkg.sv
// Package of constants, states and carriers for the converter mode control
package dcdc_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SW_HZ = 3_000_000;
  // Switching period in clk cycles, rounded down (nominal 3 MHz)
  localparam int SW_DIV = (CLK_HZ / SW_HZ < 1) ? 1 : CLK_HZ / SW_HZ;
  localparam int SS_STEP_NS = 170_000;
  localparam int SS_STEP_CYC = (SS_STEP_NS * (CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int SS_STEPS = 3;

  // ----------------------------------------------------------------
  // Current limit codes (mA)
  // ----------------------------------------------------------------
  localparam logic [11:0] OCL_STEP_MA = 12'h12c;
  localparam logic [11:0] OCL_CV_MA = 12'h960;
  localparam logic [11:0] OCL_OFF_MA = 12'h000;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_TRICKLE = 3'h1,
    ST_PRE = 3'h3,
    ST_FAST = 3'h2,
    ST_TAPER = 3'h6,
    ST_SOFT = 3'h7,
    ST_FEED = 3'h5
  } conv_state_e;

  // Analog comparator results on the battery and sense inputs
  typedef struct packed {
    logic batt_low;      // Feedback at or below trickle threshold
    logic batt_fast;     // Feedback at or above fast threshold
    logic batt_cv;       // Feedback at or above CV target
    logic current_term;  // Sense current at or below termination level
  } sense_s;

  // Host configuration bits
  typedef struct packed {
    logic converter_enable_bit;
    logic mode_select_bit;
    logic trickle_enable_bit;
    logic termination_enable_bit;
    logic cap_modulation_bit;
    logic res_modulation_bit;
    logic mod_use_bits;
  } config_s;

endpackage

// >>> verif/dcdc_ctrl_asserts.sv
// Concurrent checks on the converter mode and modulation control ports
`timescale 1ns/10ps
module dcdc_ctrl_chk
  import dcdc_ctrl_pkg::*;
#(
  parameter int SS_CYCLES = 4
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_set_in,
  input wire logic enable_clear_in,
  input config_s cfg_in,
  input wire logic protection_stop_in,
  input sense_s sense_in,
  input wire logic cap_modulation_input_in,
  input wire logic res_modulation_input_in,
  input wire logic converter_enable_bit_out,
  input conv_state_e state_out,
  input wire logic converter_status_out,
  input wire logic switch_pulse_out,
  input wire logic cap_switch_out_a_oe_out,
  input wire logic cap_switch_out_b_oe_out,
  input wire logic resistor_switch_out_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Status pin lags the state by one register stage
  property p_stat;
    converter_status_out == ($past(state_out) == ST_WAIT);
  endproperty
  a_stat: assert property (p_stat) else $error("status pin wrong");
  property p_clr;
    enable_clear_in |=> !converter_enable_bit_out ##1 state_out == ST_WAIT;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_set;
    enable_set_in && !enable_clear_in && state_out == ST_WAIT
      |=> converter_enable_bit_out;
  endproperty
  a_set: assert property (p_set) else $error("set ignored");
  property p_mode;
    $rose(converter_enable_bit_out) && !cfg_in.trickle_enable_bit
      |=> state_out == (cfg_in.mode_select_bit ? ST_SOFT : ST_PRE);
  endproperty
  a_mode: assert property (p_mode) else $error("wrong start mode");
  property p_sw;
    switch_pulse_out |=> !switch_pulse_out [*2];
  endproperty
  a_sw: assert property (p_sw) else $error("pulse too early");
  property p_sw3;
    (switch_pulse_out && state_out != ST_WAIT)
      ##1 (state_out != ST_WAIT) [*2] |=> switch_pulse_out;
  endproperty
  a_sw3: assert property (p_sw3) else $error("pulse missing");
  property p_prot;
    protection_stop_in [*8]
      |-> state_out == ST_WAIT && !converter_enable_bit_out;
  endproperty
  a_prot: assert property (p_prot) else $error("no protection stop");
  property p_term;
    (cfg_in.termination_enable_bit && sense_in.current_term) [*8]
      |-> state_out != ST_TAPER;
  endproperty
  a_term: assert property (p_term) else $error("no termination");
  property p_bits;
    (cfg_in.mod_use_bits && $stable(cfg_in)) [*7]
      |-> cap_switch_out_a_oe_out == cfg_in.cap_modulation_bit
      && resistor_switch_out_oe_out == cfg_in.res_modulation_bit;
  endproperty
  a_bits: assert property (p_bits) else $error("bit modulation wrong");
  property p_cap;
    (!cfg_in.mod_use_bits && $stable(cap_modulation_input_in)) [*7]
      |-> cap_switch_out_a_oe_out == cap_modulation_input_in
      && cap_switch_out_b_oe_out == cap_modulation_input_in;
  endproperty
  a_cap: assert property (p_cap) else $error("cap switch wrong");
  property p_res;
    (!cfg_in.mod_use_bits && $stable(res_modulation_input_in)) [*7]
      |-> resistor_switch_out_oe_out == res_modulation_input_in;
  endproperty
  a_res: assert property (p_res) else $error("res switch wrong");
endmodule // dcdc_ctrl_chk

bind dcdc_mode_and_ask_control dcdc_ctrl_chk #(.SS_CYCLES(SS_CYCLES))
  chk_i (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .enable_set_in(enable_set_in),
  .enable_clear_in(enable_clear_in),
  .cfg_in(cfg_in),
  .protection_stop_in(protection_stop_in),
  .sense_in(sense_in),
  .cap_modulation_input_in(cap_modulation_input_in),
  .res_modulation_input_in(res_modulation_input_in),
  .converter_enable_bit_out(converter_enable_bit_out),
  .state_out(state_out),
  .converter_status_out(converter_status_out),
  .switch_pulse_out(switch_pulse_out),
  .cap_switch_out_a_oe_out(cap_switch_out_a_oe_out),
  .cap_switch_out_b_oe_out(cap_switch_out_b_oe_out),
  .resistor_switch_out_oe_out(resistor_switch_out_oe_out)
);

// >>> verif/host_model.sv
// Host controller model: enable writes and modulation data stream
`timescale 1ns/10ps
module host_model (
  input wire logic clk_in,
  output logic set_out,
  output logic clear_out,
  output logic cap_out,
  output logic res_out
);
  initial
  begin
    {set_out, clear_out, cap_out, res_out} = 4'h0;
  end
  // One-cycle write pulses, launched away from the sampling edge
  task automatic wr(input logic s, input logic c);
    @(negedge clk_in);
    set_out = s;
    clear_out = c;
    @(negedge clk_in);
    set_out = 1'b0;
    clear_out = 1'b0;
  endtask
  task automatic mod(input logic c, input logic r);
    @(negedge clk_in);
    cap_out = c;
    res_out = r;
  endtask
endmodule // host_model

// >>> verif/testbench.sv
// Self-checking bench for the converter mode and modulation control
`timescale 1ns/10ps
module testbench import dcdc_ctrl_pkg::*;;
  localparam int SS = 4;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic protection_stop_in = 1'b0;
  config_s cfg_in = '0;
  sense_s sense_in = '0;
  logic enable_set_in, enable_clear_in;
  logic cap_modulation_input_in, res_modulation_input_in;
  logic converter_enable_bit_out, converter_status_out, switch_pulse_out;
  conv_state_e state_out;
  logic [11:0] current_limit_out;
  logic cap_switch_out_a_out, cap_switch_out_a_oe_out;
  logic cap_switch_out_b_out, cap_switch_out_b_oe_out;
  logic resistor_switch_out_out, resistor_switch_out_oe_out;
  int n_errors = 0;
  int checks_done = 0;
  always #50 clk_in = ~clk_in;
  dcdc_mode_and_ask_control #(.SS_CYCLES(SS)) DUT (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_set_in(enable_set_in),
    .enable_clear_in(enable_clear_in),
    .cfg_in(cfg_in),
    .protection_stop_in(protection_stop_in),
    .sense_in(sense_in),
    .cap_modulation_input_in(cap_modulation_input_in),
    .res_modulation_input_in(res_modulation_input_in),
    .converter_enable_bit_out(converter_enable_bit_out),
    .state_out(state_out),
    .converter_status_out(converter_status_out),
    .switch_pulse_out(switch_pulse_out),
    .current_limit_out(current_limit_out),
    .cap_switch_out_a_out(cap_switch_out_a_out),
    .cap_switch_out_a_oe_out(cap_switch_out_a_oe_out),
    .cap_switch_out_b_out(cap_switch_out_b_out),
    .cap_switch_out_b_oe_out(cap_switch_out_b_oe_out),
    .resistor_switch_out_out(resistor_switch_out_out),
    .resistor_switch_out_oe_out(resistor_switch_out_oe_out)
  );
  host_model host (.clk_in(clk_in), .set_out(enable_set_in),
    .clear_out(enable_clear_in), .cap_out(cap_modulation_input_in),
    .res_out(res_modulation_input_in));
  task automatic chk(input string what, input logic [11:0] exp, got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Bounded wait; a miss ends the run
  task automatic wait_st(input conv_state_e s);
    for (int k = 0; k < 60 && state_out !== s; k++)
      cyc(1);
    chk("state", s, state_out);
    if (state_out !== s)
      final_report();
  endtask
  initial
  begin
    int i;
    cyc(2);
    chk("status", 1, converter_status_out);
    cyc(8);
    rst_n_in = 1'b1;
    cfg_in.termination_enable_bit = 1'b1;
    host.wr(1, 0);
    wait_st(ST_PRE);
    i = 0;
    repeat (30)
    begin
      cyc(1);
      i += int'(switch_pulse_out);
    end
    chk("pulses", 12'h00a, 12'(i));
    chk("status", 0, converter_status_out);
    sense_in.batt_fast = 1'b1;
    wait_st(ST_FAST);
    sense_in.batt_cv = 1'b1;
    wait_st(ST_TAPER);
    sense_in.current_term = 1'b1;
    wait_st(ST_WAIT);
    chk("enable", 0, converter_enable_bit_out);
    // Keep the stop condition up long enough for the checker to see it
    cyc(4);
    sense_in = '0;
    $display("Test charge done");
    cfg_in.trickle_enable_bit = 1'b1;
    sense_in.batt_low = 1'b1;
    // Comparator levels need the synchroniser delay before enable
    cyc(6);
    host.wr(1, 0);
    wait_st(ST_TRICKLE);
    sense_in.batt_low = 1'b0;
    wait_st(ST_PRE);
    host.wr(1, 1);
    wait_st(ST_WAIT);
    chk("enable", 0, converter_enable_bit_out);
    $display("Test trickle done");
    cfg_in.mode_select_bit = 1'b1;
    cfg_in.trickle_enable_bit = 1'b0;
    host.wr(1, 0);
    wait_st(ST_SOFT);
    for (i = 0; i < 60 && current_limit_out !== OCL_STEP_MA; i++)
      cyc(1);
    chk("limit", OCL_STEP_MA, current_limit_out);
    for (i = 2; i < 5; i++)
    begin
      cyc(SS);
      chk("limit", i < 4 ? 12'(OCL_STEP_MA * i) : OCL_CV_MA,
        current_limit_out);
    end
    chk("state", ST_FEED, state_out);
    protection_stop_in = 1'b1;
    wait_st(ST_WAIT);
    chk("enable", 0, converter_enable_bit_out);
    cyc(4);
    protection_stop_in = 1'b0;
    $display("Test feed done");
    for (i = 0; i < 8; i++)
    begin
      cfg_in.mod_use_bits = i[2];
      cfg_in.cap_modulation_bit = ~i[0];
      cfg_in.res_modulation_bit = ~i[1];
      host.mod(i[0], i[1]);
      cyc(8);
      chk("cap_a", i[0] ^ i[2], cap_switch_out_a_oe_out);
      chk("cap_b", i[0] ^ i[2], cap_switch_out_b_oe_out);
      chk("res", i[1] ^ i[2], resistor_switch_out_oe_out);
      chk("levels", 0, {cap_switch_out_a_out, cap_switch_out_b_out,
        resistor_switch_out_out});
    end
    $display("Test modulation done");
    final_report();
  end
endmodule // testbench
